// ===== rocof_defines.vh
`ifndef ROCOF_DEFINES_VH
`define ROCOF_DEFINES_VH
// Register offsets
`define A_CTRL 12'h000
`define A_EXCESS 12'h004
`define A_PART_LO 12'h008
`define A_PART_HI 12'h00c
`define A_STATUS 12'h010
`define A_STAGES 12'h014
`define A_SEL 12'h018
`define A_RATIO 12'h01c
`define A_CNT_ST 12'h020
`define A_CNT_BLK 12'h024
`define A_REC_TIME 12'h028
`define A_REC_INFO 12'h02c
`define A_REC_PF 12'h030
`define A_REC_FF 12'h034
`define A_REC_SL 12'h038
`define A_STAGE_BASE 4'h1
`define S_CFG 2'h0
`define S_PICKUP 2'h1
`define S_LIMIT 2'h2
`define S_DELAY 2'h3
// Control fields
`define C_MODE 2:0
`define C_FORCE_OK 3
`define C_EV_ON 4
`define C_EV_OFF 5
`define C_GROUP 8:6
`define C_REF 10:9
`define C_CLR_CNT 11
// Stage config fields
`define G_EN 0
`define G_DIR 2:1
`define G_LIM 3
`define G_FORCE 5:4
// Modes
`define M_ON 3'h0
`define M_BLK 3'h1
`define M_TEST 3'h2
`define M_TBLK 3'h3
`define M_OFF 3'h4
`define D_RISE 2'h0
`define D_FALL 2'h1
`define D_BOTH 2'h2
// Reset values
`define R_CTRL 32'h00000030
`define R_EXCESS 16'h4e20
`define R_CFG 8'h00
`define R_PICKUP 16'h00c8
`define R_LIM 32'h13ec1383
`define R_DELAY 20'h00064
// Timing
`define CLK_NS 10
`define TICK_NS 5000000
`define TICK_MS 20'h00005
`define HYST 16'h0064
`define PRE_TICKS 4
`define RECS 12
`endif

// ===== rocof_function_block.v
// Notes on behaviour
// - Eight stages, each enabled, default off
// - Stage joins only in flagged setting group
// - Direction: rising, falling or both
// - Pick-up when slope exceeds threshold
// - Release 100 mHz/s below threshold
// - Frequency limits selectable, default unused
// - Falling needs frequency under lower limit
// - Rising needs frequency above upper limit
// - Excessive slope blocks whole function
// - Block sampled each cycle until blocked; start otherwise
// - Blocked at pick-up gives blocked only
// - Block during start drops start, releases
// - Trip after fixed definite delay
// - Force status when globally allowed
// - Operating setting and behaviour readable
// - Timestamped on/off events, filterable
// - Resettable start, trip, blocked counters
// - Twelve circular operation records
// - Records hold 20 ms earlier values
// - Slope and per-stage ratio readable
// - Slope from one of three references
//
// Implementation choices: the placing of the registers and the APB slave port.
`include "rocof_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module rocof_function_block #(
	parameter TICK_CYCLES = `TICK_NS / `CLK_NS
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [23:0] freq_ref1,
	input wire [23:0] freq_ref2,
	input wire [23:0] freq_ref3,
	input wire [7:0] block_in,
	output reg [7:0] start_out,
	output reg [7:0] trip_out,
	output reg [7:0] blocked_out,
	output reg ev_valid,
	output reg [5:0] ev_code,
	output reg [31:0] ev_time
);
function [15:0] sat16;
	input [25:0] v;
	begin
		if (!v[25] && v[24:15] != 10'h000)
			sat16 = 16'h7fff;
		else if (v[25] && v[24:15] != 10'h3ff)
			sat16 = 16'h8001;
		else
			sat16 = v[15:0];
	end
endfunction
function [15:0] mag16;
	input [15:0] v;
	begin
		mag16 = v[15] ? (~v + 16'h0001) : v;
	end
endfunction
reg [31:0] ctrl;
reg [15:0] excess;
reg [63:0] part;
reg [7:0] cfg [0:7];
reg [15:0] pku [0:7];
reg [31:0] lim [0:7];
reg [19:0] dly [0:7];
reg [19:0] tmr [0:7];
reg [7:0] sel;
reg [7:0] pick;
reg [7:0] s_start;
reg [7:0] s_trip;
reg [7:0] s_blk;
reg [7:0] f_start;
reg [7:0] f_trip;
reg [7:0] f_blk;
reg [23:0] pend;
reg [23:0] prev_stat;
reg [15:0] cnt_st;
reg [15:0] cnt_tr;
reg [15:0] cnt_bk;
reg [31:0] tick_cnt;
reg [31:0] stamp;
reg tick;
reg primed;
reg [23:0] fcur;
reg [15:0] slope;
reg [15:0] hs [0:3];
reg [23:0] hf [0:3];
reg [31:0] rec_time [0:11];
reg [8:0] rec_info [0:11];
reg [23:0] rec_pf [0:11];
reg [23:0] rec_ff [0:11];
reg [31:0] rec_sl [0:11];
reg [3:0] wptr;
integer i;
integer j;
integer k;
integer m;
integer n;
wire wr = psel & penable & pwrite;
wire stg = paddr[11:8] == `A_STAGE_BASE && !paddr[7];
wire [2:0] si = paddr[6:4];
wire [2:0] mode = ctrl[`C_MODE];
wire [2:0] grp = ctrl[`C_GROUP];
wire test = mode == `M_TEST || mode == `M_TBLK;
wire mblk = mode == `M_BLK || mode == `M_TBLK;
wire [3:0] ri = sel[7:4] < `RECS ? sel[7:4] : 4'h0;
wire [23:0] fsel = ctrl[`C_REF] == 2'h1 ? freq_ref2 :
	ctrl[`C_REF] == 2'h2 ? freq_ref3 : freq_ref1;
wire [25:0] diff = {2'b00, fsel} - {2'b00, fcur};
wire [15:0] next_slope = sat16({diff[24:0], 1'b0});
wire [15:0] amag = mag16(slope);
wire rising = !slope[15] && slope != 16'h0000;
wire falling = slope[15];
wire excess_hit = amag > excess;
wire [23:0] ratio_num = amag * 8'd200;
wire [15:0] rpk = pku[sel[2:0]];
wire [23:0] ratio = rpk == 16'h0000 ? 24'hffffff : ratio_num / rpk;
assign pready = 1'b1;
reg mapped;
always @* begin
	mapped = 1'b1;
	prdata = 32'h00000000;
	if (stg) begin
		case (paddr[3:2])
			`S_CFG: prdata = {24'h000000, cfg[si]};
			`S_PICKUP: prdata = {16'h0000, pku[si]};
			`S_LIMIT: prdata = lim[si];
			default: prdata = {12'h000, dly[si]};
		endcase
	end else begin
		case (paddr)
			`A_CTRL: prdata = {20'h00000, 1'b0, ctrl[10:0]};
			`A_EXCESS: prdata = {16'h0000, excess};
			`A_PART_LO: prdata = part[31:0];
			`A_PART_HI: prdata = part[63:32];
			`A_STATUS: prdata = {slope, 13'h0000, mode};
			`A_STAGES: prdata = {8'h00, f_blk, f_trip, f_start};
			`A_SEL: prdata = {24'h000000, sel};
			`A_RATIO: prdata = {8'h00, ratio};
			`A_CNT_ST: prdata = {cnt_tr, cnt_st};
			`A_CNT_BLK: prdata = {16'h0000, cnt_bk};
			`A_REC_TIME: prdata = rec_time[ri];
			`A_REC_INFO: prdata = {19'h00000, wptr, rec_info[ri]};
			`A_REC_PF: prdata = {8'h00, rec_pf[ri]};
			`A_REC_FF: prdata = {8'h00, rec_ff[ri]};
			`A_REC_SL: prdata = rec_sl[ri];
			default: mapped = 1'b0;
		endcase
	end
end
assign pslverr = psel & penable & ~mapped;
// Program cycle time base
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		tick_cnt <= 32'h00000000;
		tick <= 1'b0;
		stamp <= 32'h00000000;
	end else begin
		tick <= tick_cnt == TICK_CYCLES - 1;
		if (tick_cnt == TICK_CYCLES - 1) begin
			tick_cnt <= 32'h00000000;
			stamp <= stamp + 32'h00000001;
		end else begin
			tick_cnt <= tick_cnt + 32'h00000001;
		end
	end
end
// Register writes
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		ctrl <= `R_CTRL;
		excess <= `R_EXCESS;
		part <= 64'h0000000000000000;
		sel <= 8'h00;
		for (j = 0; j < 8; j = j + 1) begin
			cfg[j] <= `R_CFG;
			pku[j] <= `R_PICKUP;
			lim[j] <= `R_LIM;
			dly[j] <= `R_DELAY;
		end
	end else if (wr) begin
		if (stg) begin
			case (paddr[3:2])
				`S_CFG: cfg[si] <= pwdata[7:0];
				`S_PICKUP: pku[si] <= pwdata[15:0];
				`S_LIMIT: lim[si] <= pwdata;
				default: dly[si] <= pwdata[19:0];
			endcase
		end else begin
			case (paddr)
				`A_CTRL: ctrl <= {21'h000000, pwdata[10:0]};
				`A_EXCESS: excess <= pwdata[15:0];
				`A_PART_LO: part[31:0] <= pwdata;
				`A_PART_HI: part[63:32] <= pwdata;
				`A_SEL: sel <= pwdata[7:0];
				default: sel <= sel;
			endcase
		end
	end
end
// Stage evaluation
reg [7:0] next_pick;
reg [7:0] perm;
reg [7:0] act;
reg ok;
reg [15:0] rel;
always @* begin
	for (k = 0; k < 8; k = k + 1) begin
		act[k] = cfg[k][`G_EN] && part[{grp, k[2:0]}] && mode != `M_OFF;
		case (cfg[k][`G_DIR])
			`D_RISE: ok = rising;
			`D_FALL: ok = falling;
			default: ok = rising | falling;
		endcase
		rel = pku[k] > `HYST ? pku[k] - `HYST : 16'h0000;
		if (!act[k] || !ok)
			next_pick[k] = 1'b0;
		else if (amag > pku[k])
			next_pick[k] = 1'b1;
		else if (amag < rel)
			next_pick[k] = 1'b0;
		else
			next_pick[k] = pick[k];
		perm[k] = 1'b1;
		if (cfg[k][`G_LIM]) begin
			perm[k] = 1'b0;
			if (cfg[k][`G_DIR] != `D_RISE && falling && fcur < lim[k][15:0] * 11'd1000)
				perm[k] = 1'b1;
			if (cfg[k][`G_DIR] != `D_FALL && rising && fcur > lim[k][31:16] * 11'd1000)
				perm[k] = 1'b1;
		end
	end
end
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		fcur <= 24'h000000;
		primed <= 1'b0;
		slope <= 16'h0000;
		pick <= 8'h00;
		s_start <= 8'h00;
		s_trip <= 8'h00;
		s_blk <= 8'h00;
		for (i = 0; i < 8; i = i + 1)
			tmr[i] <= 20'h00000;
		for (i = 0; i < 4; i = i + 1) begin
			hs[i] <= 16'h0000;
			hf[i] <= 24'h000000;
		end
	end else if (tick) begin
		fcur <= fsel;
		primed <= 1'b1;
		// No slope until a previous sample exists
		slope <= primed ? next_slope : 16'h0000;
		hs[0] <= slope;
		hf[0] <= fcur;
		for (i = 1; i < `PRE_TICKS; i = i + 1) begin
			hs[i] <= hs[i-1];
			hf[i] <= hf[i-1];
		end
		pick <= next_pick;
		for (i = 0; i < 8; i = i + 1) begin
			if (!(next_pick[i] && perm[i] && act[i])) begin
				s_start[i] <= 1'b0;
				s_trip[i] <= 1'b0;
				s_blk[i] <= 1'b0;
				tmr[i] <= 20'h00000;
			end else if (s_blk[i]) begin
				s_blk[i] <= 1'b1;
			end else if (!s_start[i]) begin
				if (block_in[i] | excess_hit | mblk)
					s_blk[i] <= 1'b1;
				else
					s_start[i] <= 1'b1;
				tmr[i] <= 20'h00000;
			end else if (block_in[i] | excess_hit | mblk) begin
				s_start[i] <= 1'b0;
				s_trip[i] <= 1'b0;
				tmr[i] <= 20'h00000;
			end else begin
				tmr[i] <= tmr[i] + `TICK_MS;
				if (tmr[i] + `TICK_MS >= dly[i])
					s_trip[i] <= 1'b1;
			end
		end
	end
end
// Forced and visible status
always @* begin
	for (m = 0; m < 8; m = m + 1) begin
		f_start[m] = s_start[m];
		f_trip[m] = s_trip[m];
		f_blk[m] = s_blk[m];
		if (ctrl[`C_FORCE_OK] && cfg[m][`G_FORCE] != 2'h0) begin
			f_start[m] = cfg[m][`G_FORCE] != 2'h3;
			f_trip[m] = cfg[m][`G_FORCE] == 2'h2;
			f_blk[m] = cfg[m][`G_FORCE] == 2'h3;
		end
		if (!cfg[m][`G_EN] || mode == `M_OFF) begin
			f_start[m] = 1'b0;
			f_trip[m] = 1'b0;
			f_blk[m] = 1'b0;
		end
	end
end
// Event scan, lowest pending first
wire [23:0] cur_stat = {f_blk, f_trip, f_start};
reg [4:0] eidx;
reg efound;
always @* begin
	eidx = 5'h00;
	efound = 1'b0;
	for (n = 23; n >= 0; n = n - 1) begin
		if (pend[n]) begin
			eidx = n[4:0];
			efound = 1'b1;
		end
	end
end
wire [1:0] ekind = eidx >= 5'd16 ? 2'h2 : (eidx >= 5'd8 ? 2'h1 : 2'h0);
wire eon = cur_stat[eidx];
wire [23:0] eclr = efound ? (24'h000001 << eidx) : 24'h000000;
wire clr_cnt = wr && !stg && paddr == `A_CTRL && pwdata[`C_CLR_CNT];
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		start_out <= 8'h00;
		trip_out <= 8'h00;
		blocked_out <= 8'h00;
		prev_stat <= 24'h000000;
		pend <= 24'h000000;
		ev_valid <= 1'b0;
		ev_code <= 6'h00;
		ev_time <= 32'h00000000;
		cnt_st <= 16'h0000;
		cnt_tr <= 16'h0000;
		cnt_bk <= 16'h0000;
		wptr <= 4'h0;
	end else begin
		start_out <= test ? 8'h00 : f_start;
		trip_out <= test ? 8'h00 : f_trip;
		blocked_out <= test ? 8'h00 : f_blk;
		prev_stat <= cur_stat;
		pend <= (pend & ~eclr) | (cur_stat ^ prev_stat);
		ev_valid <= efound && (eon ? ctrl[`C_EV_ON] : ctrl[`C_EV_OFF]);
		ev_code <= {eon, ekind, eidx[2:0]};
		ev_time <= stamp;
		if (clr_cnt) begin
			cnt_st <= 16'h0000;
			cnt_tr <= 16'h0000;
			cnt_bk <= 16'h0000;
		end
		if (efound && eon) begin
			case (ekind)
				2'h0: cnt_st <= (clr_cnt ? 16'h0000 : cnt_st) + 16'h0001;
				2'h1: cnt_tr <= (clr_cnt ? 16'h0000 : cnt_tr) + 16'h0001;
				default: cnt_bk <= (clr_cnt ? 16'h0000 : cnt_bk) + 16'h0001;
			endcase
		end
		if (efound && eon && ekind != 2'h2)
			wptr <= wptr == `RECS - 1 ? 4'h0 : wptr + 4'h1;
	end
end
// Record store, no reset needed
always @(posedge pclk) begin
	if (efound && eon && ekind != 2'h2) begin
		rec_time[wptr] <= stamp;
		rec_info[wptr] <= {grp, eon, ekind, eidx[2:0]};
		rec_pf[wptr] <= hf[`PRE_TICKS-1];
		rec_ff[wptr] <= fcur;
		rec_sl[wptr] <= {hs[`PRE_TICKS-1], slope};
	end
end
endmodule
`default_nettype wire

// ===== rocof_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rocof_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] start_out,
	input wire logic [7:0] trip_out,
	input wire logic [7:0] blocked_out,
	input wire logic ev_valid,
	input wire logic [5:0] ev_code,
	input wire logic [31:0] ev_time
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [31:0] last_time;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			last_time <= 32'h00000000;
		else if (ev_valid)
			last_time <= ev_time;
	reset_quiet_a: assert property ($rose(presetn) |-> !(start_out | trip_out | blocked_out))
		else $error("stage output after reset");
	block_excl_a: assert property ((blocked_out & (start_out | trip_out)) == 8'h00)
		else $error("blocked with start or trip");
	ev_kind_a: assert property (ev_valid |-> ev_code[4:3] != 2'b11)
		else $error("bad event kind");
	ev_time_order_a: assert property (ev_valid |-> ev_time >= last_time)
		else $error("event time went back");
	start_event_a: assert property ($rose(start_out[0]) |-> ##[1:60] (ev_valid && ev_code == 6'h20))
		else $error("no start on event");
	trip_event_a: assert property ($rose(trip_out[0]) |-> ##[1:60] (ev_valid && ev_code == 6'h28))
		else $error("no trip on event");
	blocked_event_a: assert property ($rose(blocked_out[0]) |-> ##[1:60] (ev_valid && ev_code == 6'h30))
		else $error("no blocked on event");
	trip_after_start_a: assert property ($rose(trip_out[0]) |-> $past(start_out[0]))
		else $error("trip without start");
endmodule
`default_nettype wire

// ===== freq_source.sv
`timescale 1ns/1ps
`default_nettype none
module freq_source #(
	parameter int TICK = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic signed [23:0] step,
	input wire logic [7:0] blk_req,
	output logic [23:0] freq_ref1,
	output logic [23:0] freq_ref2,
	output logic [23:0] freq_ref3,
	output logic [7:0] block_in
);
	int cnt;
	// New frequency sample and block state every TICK clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			freq_ref1 <= 24'h4c4b40;
			block_in <= 8'h00;
		end else begin
			cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
			if (cnt == TICK - 1) begin
				freq_ref1 <= freq_ref1 + step;
				block_in <= blk_req;
			end
		end
	end
	assign freq_ref2 = freq_ref1 + 24'h000010;
	assign freq_ref3 = freq_ref1 - 24'h000010;
endmodule
`default_nettype wire

// ===== rocof_protection_stages_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rocof_protection_stages_tb;
	localparam int TICK = 20;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] r;
	logic serr;
	logic signed [23:0] step = 24'sh000000;
	logic [7:0] blk_req = 8'h00;
	logic [31:0] prdata, ev_time;
	logic pready, pslverr, ev_valid;
	logic [23:0] freq_ref1, freq_ref2, freq_ref3;
	logic [7:0] block_in, start_out, trip_out, blocked_out;
	logic [5:0] ev_code;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
	rocof_function_block #(.TICK_CYCLES(TICK)) uut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .freq_ref1, .freq_ref2, .freq_ref3,
		.block_in, .start_out, .trip_out, .blocked_out, .ev_valid, .ev_code, .ev_time);
	freq_source #(.TICK(TICK)) src (.pclk, .presetn, .step, .blk_req, .freq_ref1, .freq_ref2,
		.freq_ref3, .block_in);
	initial forever #5 pclk = ~pclk;
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			results();
		end
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h00000000);
		chk(n, e, r);
	endtask
	task automatic ticks(input int n);
		repeat (n * TICK) @(posedge pclk);
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h000, 32'h00000030, "ctrl");
		rd(12'h004, 32'h00004e20, "excess");
		rd(12'h100, 32'h00000000, "cfg");
		rd(12'h104, 32'h000000c8, "pickup");
		rd(12'h108, 32'h13ec1383, "limits");
		apb(1'b0, 12'h3fc, 32'h00000000);
		chk("slverr", 32'h00000001, {31'h0, serr});
		$display("test defaults done");
		// Stage 1 falling, stage 3 not in group, stage 4 disabled
		apb(1'b1, 12'h008, 32'h00000017);
		apb(1'b1, 12'h100, 32'h00000001);
		apb(1'b1, 12'h110, 32'h00000003);
		apb(1'b1, 12'h120, 32'h00000001);
		apb(1'b1, 12'h130, 32'h00000001);
		blk_req <= 8'h04;
		step <= 24'sd250;
		ticks(4);
		chk("start", 32'h01, start_out);
		chk("blocked", 32'h04, blocked_out);
		apb(1'b1, 12'h018, 32'h00000000);
		rd(12'h01c, 32'h000001f4, "ratio");
		rd(12'h010, 32'h01f40000, "status");
		$display("test pickup done");
		ticks(15);
		chk("trip early", 32'h00, trip_out);
		ticks(6);
		chk("trip", 32'h01, trip_out);
		rd(12'h020, 32'h00010001, "counts");
		rd(12'h02c, 32'h00000420, "record");
		apb(1'b1, 12'h000, 32'h00000830);
		rd(12'h020, 32'h00000000, "cleared");
		$display("test trip done");
		step <= 24'sd75;
		ticks(4);
		chk("hold", 32'h01, start_out);
		step <= 24'sd25;
		ticks(4);
		chk("release", 32'h00, start_out);
		$display("test hysteresis done");
		step <= 24'sd250;
		ticks(4);
		chk("restart", 32'h01, start_out);
		blk_req <= 8'h05;
		ticks(3);
		chk("start drop", 32'h00, start_out | trip_out);
		chk("block late", 32'h05, blocked_out);
		$display("test block done");
		apb(1'b1, 12'h000, 32'h00000032);
		ticks(2);
		chk("test pins", 32'h00, blocked_out);
		rd(12'h014, 32'h00050000, "stage status");
		apb(1'b1, 12'h000, 32'h00000034);
		ticks(2);
		chk("off", 32'h00, blocked_out);
		apb(1'b0, 12'h010, 32'h00000000);
		chk("mode", 32'h4, {29'h0, r[2:0]});
		$display("test mode done");
		results();
	end
endmodule
bind rocof_function_block rocof_checker chk_i (.pclk, .presetn, .start_out, .trip_out,
	.blocked_out, .ev_valid, .ev_code, .ev_time);
`default_nettype wire
